// ### sim/erase_link_sva.sv
/*
 Checker for the serial erase link wire: clock phases, select framing and bit count.
 Assumes the host end drives sck, sel_n and sdi from clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module erase_link_sva (
   // system
   input wire logic clk_sys,
   input wire logic arst_n,
   // link
   input wire logic sck,
   input wire logic sel_n,
   input wire logic sdi
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   logic sck_q;
   logic [5:0] rises;
   // rising link clock edges seen in the current frame
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sck_q <= 1'b0;
         rises <= 6'h00;
      end else begin
         sck_q <= sck;
         if (sel_n) rises <= 6'h00;
         else if (sck && !sck_q) rises <= rises + 6'h01;
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // each link clock phase lasts six system clocks
   sequence high_phase;
      sck [*6] ##1 !sck;
   endsequence
   sequence low_phase;
      !sck [*6] ##1 sck;
   endsequence
   sck_idle_a: assert property (sel_n |-> !sck)
      else $error("link clock moved outside a frame");
   sck_high_a: assert property ($rose(sck) |-> high_phase)
      else $error("link clock high phase has wrong length");
   sck_low_a: assert property ($fell(sck) && rises < 6'h20 |-> low_phase)
      else $error("link clock low phase has wrong length");
   frame_start_a: assert property ($fell(sel_n) |-> low_phase)
      else $error("first link clock edge misplaced");
   frame_bits_a: assert property ($rose(sel_n) |-> rises == 6'h20)
      else $error("frame did not carry 32 bits");
   frame_end_a: assert property ($fell(sck) && rises == 6'h20 |-> ##[0:8] sel_n)
      else $error("select not released after last bit");
   sdi_stable_a: assert property (sck && $past(sck) |-> $stable(sdi))
      else $error("data changed while link clock high");
   bit_limit_a: assert property (rises <= 6'h20)
      else $error("more than 32 bits in a frame");
endmodule
`default_nettype wire

// ### sim/testbench.sv
/*
 Self-checking bench: host and device joined by one link, plus a second device
 driven bit by bit by the bench to send short and overlong frames.
 Assumes the package timing counts and the command framing of both ends.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import erase_pkg::*;
   logic clk_sys, arst_n, start, binary_mode, wp_n, ready, busy, erase_pulse, erase_fill, wp_active, busy2, pulse2;
   erase_kind_e kind;
   logic [PAGE_BITS-1:0] page, erase_first_page;
   logic [PAGE_BITS:0] erase_page_count;
   logic [SECTOR_COUNT-1:0] sector_protect, erase_sector_mask, mask2;
   logic [31:0] r;
   int miscompares = 0, n_compared = 0, n_pulse = 0, n_pulse2 = 0, busy_len = 0, cycles = 0;
   int seed = 32'hDAB7;
   // reference model results: first page, page count, sector mask per command
   int exp_q[$];
   erase_link_if link();
   erase_link_if link2();
   erase_host i_erase_host (.clk_sys(clk_sys), .arst_n(arst_n), .start(start), .kind(kind),
      .binary_mode(binary_mode), .page(page), .ready(ready), .link(link));
   erase_dev i_erase_dev (.clk_sys(clk_sys), .arst_n(arst_n), .binary_mode(binary_mode), .wp_n(wp_n),
      .sector_protect(sector_protect), .busy(busy), .erase_pulse(erase_pulse), .erase_fill(erase_fill),
      .erase_first_page(erase_first_page), .erase_page_count(erase_page_count),
      .erase_sector_mask(erase_sector_mask), .wp_active(wp_active), .link(link));
   erase_dev i_erase_dev_2 (.clk_sys(clk_sys), .arst_n(arst_n), .binary_mode(1'b0), .wp_n(1'b0),
      .sector_protect(sector_protect), .busy(busy2), .erase_pulse(pulse2), .erase_fill(),
      .erase_first_page(), .erase_page_count(), .erase_sector_mask(mask2), .wp_active(), .link(link2));
   erase_link_sva i_erase_link_sva (.clk_sys(clk_sys), .arst_n(arst_n), .sck(link.sck),
      .sel_n(link.sel_n), .sdi(link.sdi));
   // ----------------------------------------------------------------
   // clock, monitors, timeout
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // pulses and busy length counted here so a one-cycle pulse is never missed
   always @(posedge clk_sys) begin
      cycles++;
      if (erase_pulse === 1'b1) n_pulse++;
      if (pulse2 === 1'b1) n_pulse2++;
      if (erase_pulse === 1'b1) busy_len = 1;
      else if (busy === 1'b1) busy_len++;
      if (cycles == 80000) begin
         miscompares++;
         summarize();
      end
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask
   // one command through the host; extra 1 = second command while busy, 2 = protect pin mid-erase
   task automatic run_cmd(input erase_kind_e k, input logic m, input logic [11:0] pg, input int cyc, input int extra);
      int p0, first, cnt, mask, s, i;
      p0 = n_pulse;
      s = pg[11:8];
      mask = 0;
      first = {pg[11:3], 3'h0};
      cnt = 8;
      if (k == KIND_SECTOR && s != 0) begin
         first = s * 256;
         cnt = 256;
         mask = 1 << s;
      end else if (k == KIND_SECTOR && pg[3]) begin
         first = 8;
         cnt = 248;
      end else if (k == KIND_CHIP) begin
         first = 0;
         cnt = 4096;
         mask = 32'h0000FFFF;
      end
      exp_q.push_back(first);
      exp_q.push_back(cnt);
      exp_q.push_back(mask);
      for (i = 0; i < 1000 && ready !== 1'b1; i++) tick();
      chk("ready", ready, 1);
      kind = k;
      binary_mode = m;
      page = pg;
      start = 1'b1;
      tick();
      start = 1'b0;
      chk("ready_low", ready, 0);
      for (i = 0; i < 1000 && n_pulse == p0; i++) tick();
      tick();
      chk("pulse", n_pulse, p0 + 1);
      chk("first", erase_first_page, exp_q.pop_front());
      chk("count", erase_page_count, exp_q.pop_front());
      chk("mask", erase_sector_mask, exp_q.pop_front());
      chk("fill", erase_fill, 1);
      if (extra == 2) wp_n = 1'b0;
      if (extra == 1) begin
         for (i = 0; i < 1000 && ready !== 1'b1; i++) tick();
         page = 12'hF00;
         start = 1'b1;
         tick();
         start = 1'b0;
      end
      repeat (600) tick();
      chk("busy", busy, 1);
      if (extra == 2) chk("wp_held", wp_active, 0);
      for (i = 0; i < cyc + 100 && busy === 1'b1; i++) tick();
      chk("busy_len", busy_len >= cyc && busy_len <= cyc + 2, 1);
      repeat (20) tick();
      chk("refused", n_pulse, p0 + 1);
      if (extra == 2) chk("wp_late", wp_active, 1);
   endtask
   // bench-driven frame on the second link, link clock at 125 ns
   task automatic send_bits(input logic [39:0] v, input int n);
      int i;
      link2.sel_n = 1'b0;
      for (i = 0; i < n; i++) begin
         link2.sdi = v[39 - i];
         #62.5 link2.sck = 1'b1;
         #62.5 link2.sck = 1'b0;
      end
      #62.5 link2.sel_n = 1'b1;
      link2.sdi = ~link2.sdi;
      repeat (20) tick();
   endtask
   task automatic summarize();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      start = 1'b0;
      kind = KIND_BLOCK;
      binary_mode = 1'b0;
      page = 12'h000;
      wp_n = 1'b1;
      r = $random(seed);
      sector_protect = r[15:0];
      link2.sck = 1'b0;
      link2.sel_n = 1'b1;
      link2.sdi = 1'b0;
      arst_n = 1'b0;
      repeat (16) @(posedge clk_sys);
      #1 arst_n = 1'b1;
      repeat (3) tick();
      r = $random(seed);
      run_cmd(KIND_BLOCK, 1'b0, r[11:0], BLOCK_ERASE_CYCLES, 1);
      run_cmd(KIND_BLOCK, 1'b1, 12'hFFF, BLOCK_ERASE_CYCLES, 0);
      r = $random(seed);
      run_cmd(KIND_SECTOR, 1'b0, {9'h000, r[2:0]}, SECTOR_ERASE_CYCLES, 0);
      run_cmd(KIND_SECTOR, 1'b1, {4'h0, r[7:4], 1'b1, r[2:0]}, SECTOR_ERASE_CYCLES, 0);
      run_cmd(KIND_SECTOR, 1'b0, {r[11:9], 1'b1, r[7:0]}, SECTOR_ERASE_CYCLES, 0);
      run_cmd(KIND_CHIP, 1'b0, r[11:0], CHIP_ERASE_CYCLES, 2);
      send_bits({OP_CHIP_1, OP_CHIP_2, OP_CHIP_3, OP_CHIP_4, r[7:0]}, 31);
      chk("short", n_pulse2, 0);
      send_bits({OP_CHIP_1, OP_CHIP_2, OP_CHIP_3, OP_CHIP_4, r[7:0]}, 40);
      chk("long", n_pulse2, 1);
      chk("busy2", busy2, 1);
      chk("mask2", mask2, SECTOR_COUNT'(~sector_protect));
      summarize();
   end
endmodule
`default_nettype wire

// ### verilog/erase_dev.sv
/*
 Device end: decodes block, sector and chip erase commands from the
 serial link and runs a self-timed erase, reporting busy meanwhile.
 Assumes the host holds select low through a whole command.
*/
// Notes on behaviour
// R01: block erase clears eight pages
// R02: host sends 50H plus standard address
// R03: host sends 50H plus binary address
// R04: nine bits pick block, low three ignored
// R05: block erase starts on select rise
// R06: erase self-timed, busy until done
// R07: sector erase clears exactly one sector
// R08: host sends 7CH for sector 0a/0b
// R09: host sends 7CH for sectors 1-15
// R10: binary 7CH for sector 0a/0b
// R11: binary 7CH for sectors 1-15
// R12: top page bits decode sector, 0 split
// R13: sector erase starts on select rise
// R14: host sends C7 94 80 9A
// R15: ignore bytes after chip sequence
// R16: chip erase starts on select rise, busy
// R17: chip erase spares protected sectors; code spares them only while wp_active is set
// R18: write protect deferred until erase ends
// R19: erased locations read all ones
// R20: host holds select low during command
// R21: incomplete command starts no erase
// R22: no new erase while busy
`timescale 1ns/10ps
`default_nettype none
module erase_dev import erase_pkg::*; (
   // system
   input wire logic clk_sys,
   input wire logic arst_n,
   // configuration and protection
   input wire logic binary_mode,
   input wire logic wp_n,
   input wire logic [SECTOR_COUNT-1:0] sector_protect,
   // memory array side
   output logic busy,
   output logic erase_pulse,
   output logic erase_fill,
   output logic [PAGE_BITS-1:0] erase_first_page,
   output logic [PAGE_BITS:0] erase_page_count,
   output logic [SECTOR_COUNT-1:0] erase_sector_mask,
   output logic wp_active,
   // link
   erase_link_if.dev link
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] sck_s;
   logic [1:0] sel_s;
   logic [1:0] sdi_s;
   logic [1:0] wp_s;
   logic sck_d;
   logic sel_d;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sck_s <= 2'b00;
         sel_s <= 2'b11;
         sdi_s <= 2'b00;
         wp_s <= 2'b11;
         sck_d <= 1'b0;
         sel_d <= 1'b1;
      end else begin
         sck_s <= {sck_s[0], link.sck};
         sel_s <= {sel_s[0], link.sel_n};
         sdi_s <= {sdi_s[0], link.sdi};
         wp_s <= {wp_s[0], wp_n};
         sck_d <= sck_s[1];
         sel_d <= sel_s[1];
      end
   end
   logic sck_rise;
   logic sel_rise;
   logic sel_low;
   assign sck_rise = sck_s[1] & ~sck_d;
   assign sel_rise = sel_s[1] & ~sel_d;
   assign sel_low = ~sel_s[1];

   // ----------------------------------------------------------------
   // command shifter
   // ----------------------------------------------------------------
   // only the first 32 bits are kept; anything after is dropped
   logic [31:0] cmd;
   logic [5:0] nbits;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cmd <= 32'h00000000;
         nbits <= 6'h00;
      end else if (!sel_low) begin
         nbits <= 6'h00;
      end else if (sck_rise && nbits != 6'h20) begin
         cmd <= {cmd[30:0], sdi_s[1]};
         nbits <= nbits + 6'h01; // R15
      end
   end

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic [PAGE_BITS-1:0] page;
   logic [3:0] sect;
   logic is_block;
   logic is_sector;
   logic is_chip;
   logic complete;
   logic [SECTOR_COUNT-1:0] chip_mask;
   always_comb begin
      if (binary_mode) begin
         page = cmd[BIN_PAGE_LSB +: PAGE_BITS];
      end else begin
         page = cmd[STD_PAGE_LSB +: PAGE_BITS];
      end
   end
   assign sect = page[PAGE_BITS-1 -: 4];                  // R12
   assign complete = (nbits == 6'h20);                    // R21
   assign is_block = complete && cmd[31:24] == OP_BLOCK_ERASE;
   assign is_sector = complete && cmd[31:24] == OP_SECTOR_ERASE;
   assign is_chip = complete && cmd == {OP_CHIP_1, OP_CHIP_2, OP_CHIP_3, OP_CHIP_4};
   // protection applies only through the latched write-protect state
   assign chip_mask = wp_active ? ~sector_protect : {SECTOR_COUNT{1'b1}}; // R17

   // ----------------------------------------------------------------
   // erase sequencer
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      D_IDLE = 2'b00,
      D_BUSY = 2'b01
   } dev_state_e;
   dev_state_e state;
   logic [CNT_BITS-1:0] timer;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state <= D_IDLE;
         timer <= '0;
         busy <= 1'b0;
         erase_pulse <= 1'b0;
         erase_first_page <= '0;
         erase_page_count <= '0;
         erase_sector_mask <= '0;
      end else begin
         erase_pulse <= 1'b0;
         case (state)
            D_IDLE: begin
               if (sel_rise && (is_block || is_sector || is_chip)) begin // R05 R13 R16
                  state <= D_BUSY;
                  busy <= 1'b1; // R06
                  erase_pulse <= 1'b1;
                  if (is_block) begin
                     erase_first_page <= {page[PAGE_BITS-1:3], 3'b000}; // R01 R04
                     erase_page_count <= 13'h0008;
                     erase_sector_mask <= '0;
                     timer <= CNT_BITS'(BLOCK_ERASE_CYCLES);
                  end else if (is_sector) begin
                     // one sector only; sector 0 split by page bit 3
                     erase_sector_mask <= '0;
                     if (sect == 4'h0) begin
                        erase_first_page <= page[3] ? 12'h008 : 12'h000; // R07 R12
                        erase_page_count <= page[3] ? 13'h00F8 : 13'h0008;
                     end else begin
                        erase_first_page <= {sect, 8'h00};
                        erase_page_count <= 13'h0100;
                        erase_sector_mask[sect] <= 1'b1; // R07
                     end
                     timer <= CNT_BITS'(SECTOR_ERASE_CYCLES);
                  end else begin
                     erase_first_page <= '0;
                     erase_page_count <= 13'h1000;
                     erase_sector_mask <= chip_mask; // R17
                     timer <= CNT_BITS'(CHIP_ERASE_CYCLES);
                  end
               end
            end
            D_BUSY: begin
               // new commands are simply not looked at here
               if (timer == '0) begin
                  state <= D_IDLE; // R22
                  busy <= 1'b0;    // R06
               end else begin
                  timer <= timer - 1'b1;
               end
            end
            default: state <= D_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // write-protect latch, frozen while an erase runs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wp_active <= 1'b0;
      end else if (state == D_IDLE) begin
         wp_active <= ~wp_s[1]; // R18
      end
   end

   // ----------------------------------------------------------------
   // erased value
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         erase_fill <= 1'b1;
      end else begin
         erase_fill <= 1'b1; // R19
      end
   end
endmodule
`default_nettype wire

// ### verilog/erase_host.sv
/*
 Host end: shifts one erase command out over the serial link.
 Assumes the user pulses start only while ready is high.
*/
`timescale 1ns/10ps
`default_nettype none
module erase_host import erase_pkg::*; (
   // system
   input wire logic clk_sys,
   input wire logic arst_n,
   // user command
   input wire logic start,
   input wire erase_kind_e kind,
   input wire logic binary_mode,
   input wire logic [PAGE_BITS-1:0] page,
   output logic ready,
   // link
   erase_link_if.host link
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SHIFT = 2'b01,
      H_END = 2'b10
   } host_state_e;
   host_state_e state;
   logic [39:0] shreg;
   logic [5:0] bits_left;
   logic [3:0] div;
   logic sck_r;
   logic sel_n_r;
   logic sdi_r;
   logic [23:0] addr;

   // ----------------------------------------------------------------
   // address framing per page-size mode
   // ----------------------------------------------------------------
   // page bits land at 20:9 or 19:8; lower don't-care bits sent as zero
   always_comb begin
      if (binary_mode) begin
         addr = {4'h0, page, 8'h00};  // R03 R10 R11
      end else begin
         addr = {3'h0, page, 9'h000}; // R02 R08 R09
      end
   end

   // ----------------------------------------------------------------
   // command sequencer with clock divider
   // ----------------------------------------------------------------
   // sck idles low, data changes on falling edge, device samples rising
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state <= H_IDLE;
         shreg <= 40'h0000000000;
         bits_left <= 6'h00;
         div <= 4'h0;
         sck_r <= 1'b0;
         sel_n_r <= 1'b1;
         sdi_r <= 1'b0;
         ready <= 1'b1;
      end else begin
         case (state)
            H_IDLE: begin
               if (start) begin
                  ready <= 1'b0;
                  sel_n_r <= 1'b0; // R20
                  bits_left <= 6'h20;
                  div <= 4'h0;
                  if (kind == KIND_CHIP) begin
                     shreg <= {OP_CHIP_1, OP_CHIP_2, OP_CHIP_3, OP_CHIP_4, 8'h00}; // R14
                  end else if (kind == KIND_SECTOR) begin
                     shreg <= {OP_SECTOR_ERASE, addr, 8'h00};
                  end else begin
                     shreg <= {OP_BLOCK_ERASE, addr, 8'h00};
                  end
                  // first bit must already stand on sdi before the first rise
                  sdi_r <= (kind == KIND_CHIP) ? OP_CHIP_1[7] : (kind == KIND_SECTOR) ? OP_SECTOR_ERASE[7] : OP_BLOCK_ERASE[7];
                  state <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               sdi_r <= shreg[39];
               if (div == 4'(LINK_HALF_CYCLES - 1)) begin
                  div <= 4'h0;
                  sck_r <= ~sck_r;
                  if (sck_r) begin
                     shreg <= {shreg[38:0], 1'b0};
                     bits_left <= bits_left - 6'h01;
                     if (bits_left == 6'h01) begin
                        state <= H_END;
                     end
                  end
               end else begin
                  div <= div + 4'h1;
               end
            end
            H_END: begin
               // select held low across all 32 bits, rises after last fall
               if (div == 4'(LINK_HALF_CYCLES - 1)) begin
                  sel_n_r <= 1'b1; // R16 R20
                  ready <= 1'b1;
                  div <= 4'h0;
                  state <= H_IDLE;
               end else begin
                  div <= div + 4'h1;
               end
            end
            default: state <= H_IDLE;
         endcase
      end
   end

   assign link.sck = sck_r;
   assign link.sel_n = sel_n_r;
   assign link.sdi = sdi_r;
endmodule
`default_nettype wire

// ### verilog/erase_link_if.sv
/*
 Serial command link between the host controller and the flash device.
 Assumes both ends run from their own system clocks; the host makes sck.
*/
`timescale 1ns/10ps
`default_nettype none
interface erase_link_if;
   logic sck;
   logic sel_n;
   logic sdi;
   modport host (output sck, output sel_n, output sdi);
   modport dev (input sck, input sel_n, input sdi);
endinterface
`default_nettype wire

// ### verilog/erase_pkg.sv
/*
 Constants shared by both ends of the bulk erase serial command link:
 opcodes, address field positions, geometry and erase timing counts.
 Assumes a 100 MHz system clock on both ends.
*/
package erase_pkg;
   // ----------------------------------------------------------------
   // opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h7C;
   localparam logic [7:0] OP_CHIP_1 = 8'hC7;
   localparam logic [7:0] OP_CHIP_2 = 8'h94;
   localparam logic [7:0] OP_CHIP_3 = 8'h80;
   localparam logic [7:0] OP_CHIP_4 = 8'h9A;
   // ----------------------------------------------------------------
   // geometry and address fields (24-bit address after opcode)
   // ----------------------------------------------------------------
   localparam int PAGE_BITS = 12;
   localparam int BLOCK_BITS = 9;
   localparam int SECTOR_COUNT = 16;
   localparam int STD_PAGE_LSB = 9;   // page_addr_bits at address 20:9
   localparam int BIN_PAGE_LSB = 8;   // binary_byte_addr_bits 19:8
   localparam int ADDR_BYTES = 3;
   localparam int CHIP_BYTES = 4;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int BLOCK_ERASE_TIME_US = 50;   // block_erase_time, bench-scaled
   localparam int SECTOR_ERASE_TIME_US = 100; // sector_erase_time, bench-scaled
   localparam int CHIP_ERASE_TIME_US = 200;
   localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;
   localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLK_MHZ;
   localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_US * CLK_MHZ;
   localparam int LINK_HALF_CYCLES = 6;       // host link clock divider
   localparam int CNT_BITS = 24;
   typedef enum logic [1:0] {
      KIND_BLOCK = 2'b00,
      KIND_SECTOR = 2'b01,
      KIND_CHIP = 2'b10
   } erase_kind_e;
endpackage
